// *** verilog/uef_defines.vh ***
// register map, field positions and sizes of the endpoint status and fifo access block
`ifndef UEF_DEFINES_VH
`define UEF_DEFINES_VH

`define UEF_ADDR_EPSEL   8'hc7
`define UEF_ADDR_STATUS  8'hce
`define UEF_ADDR_DATA    8'hcf
`define UEF_ADDR_COUNT   8'he2

`define UEF_B_TXDONE     0
`define UEF_B_OUTB0      1
`define UEF_B_SETUP      2
`define UEF_B_STLERR     3
`define UEF_B_TXREADY    4
`define UEF_B_STALLREQ   5
`define UEF_B_OUTB1      6
`define UEF_B_RSVD       7

`define UEF_NUM_EP       7
`define UEF_EP_W         3
`define UEF_PTR_W        7
`define UEF_MEM_AW       10
`define UEF_MEM_WORDS    1024
`define UEF_FIFO_DEPTH   8
`define UEF_FIFO_AW      3
`define UEF_FIFO_W       11

`define UEF_PTR_ZERO     7'h00
`define UEF_PTR_ONE      7'h01
`define UEF_BYTE_ZERO    8'h00
`define UEF_EPSEL_RST    3'h0

`endif

// *** verilog/uef_fifo.v ***
// small synchronous fifo between the serial engine and the endpoint buffer memory
`timescale 1ns/1ps
module uef_fifo #(
  parameter W     = 11,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // fill side
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  // drain side
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);
  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wrPtr_q;
  reg  [AW-1:0] rdPtr_q;
  reg  [AW:0]   count_q;
  reg  [AW:0]   count_d;
  reg           notFull_q;
  reg           notEmpty_q;
  wire          push;
  wire          pop;

  assign push     = inValid & notFull_q;
  assign pop      = outReady & notEmpty_q;
  assign inReady  = notFull_q;
  assign outValid = notEmpty_q;
  assign outData  = mem[rdPtr_q];

  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // flags kept as flops so ready and valid reach the ports without logic
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q    <= {AW{1'b0}};
      rdPtr_q    <= {AW{1'b0}};
      count_q    <= {(AW+1){1'b0}};
      notFull_q  <= 1'b1;
      notEmpty_q <= 1'b0;
    end else begin
      count_q    <= count_d;
      notFull_q  <= (count_d != DEPTH[AW:0]);
      notEmpty_q <= (count_d != {(AW+1){1'b0}});
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule // uef_fifo

// *** verilog/uef_endpoint_access.v ***
// per-endpoint status flags, fifo data port and received byte count for firmware
`timescale 1ns/1ps
`include "uef_defines.vh"

module uef_endpoint_access (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst_b,
  // special function register port
  input  wire [7:0]               sfrAddr,
  input  wire                     sfrWr,
  input  wire                     sfrRd,
  input  wire [7:0]               sfrWdata,
  output reg  [7:0]               sfrRdata_q,
  // endpoint configuration
  input  wire [`UEF_NUM_EP-1:0]   epIso,
  input  wire [`UEF_NUM_EP-1:0]   epPingPong,
  // received bytes from the serial engine
  input  wire                     rxValid,
  input  wire [`UEF_EP_W-1:0]     rxEp,
  input  wire [7:0]               rxData,
  output wire                     rxReady,
  output reg                      rxIdle_q,
  // packet events from the serial engine, one at a time
  input  wire [`UEF_EP_W-1:0]     evEp,
  input  wire                     evSetup,
  input  wire                     evOut,
  input  wire                     evOutBank,
  input  wire                     evOutCrcErr,
  input  wire                     evInAck,
  input  wire                     evInSent,
  input  wire                     evStallSent,
  // transmit byte fetch
  input  wire                     txRdStb,
  input  wire [`UEF_EP_W-1:0]     txEp,
  output reg  [7:0]               txData_q,
  output reg  [`UEF_PTR_W-1:0]    txLen_q,
  // per-endpoint handshake steering
  output reg  [`UEF_NUM_EP-1:0]   epStallReq_q,
  output reg  [`UEF_NUM_EP-1:0]   epTxReady_q,
  output reg  [`UEF_NUM_EP-1:0]   epNakOut_q,
  output reg  [`UEF_NUM_EP-1:0]   epIrq_q
);
  reg  [7:0]                      mem [0:`UEF_MEM_WORDS-1];
  reg  [`UEF_EP_W-1:0]            epSel_q;
  wire [8*`UEF_NUM_EP-1:0]        statusFlat;
  wire [`UEF_PTR_W*`UEF_NUM_EP-1:0] fwPtrFlat;
  wire [`UEF_PTR_W*`UEF_NUM_EP-1:0] rxPtrFlat;
  wire [`UEF_PTR_W*`UEF_NUM_EP-1:0] txPtrFlat;
  wire [`UEF_PTR_W*`UEF_NUM_EP-1:0] txCntFlat;
  wire [`UEF_PTR_W*`UEF_NUM_EP-1:0] byteCntFlat;
  wire [`UEF_NUM_EP-1:0]          stall_request;
  wire [`UEF_NUM_EP-1:0]          tx_packet_ready;
  wire [`UEF_NUM_EP-1:0]          nakNext;
  wire [`UEF_NUM_EP-1:0]          irqNext;
  wire                            stWr;
  wire                            datWr;
  wire                            datRd;
  wire                            drainValid;
  wire                            drainReady;
  wire                            drain;
  wire [`UEF_FIFO_W-1:0]          drainWord;
  wire [`UEF_EP_W-1:0]            drainEp;
  wire [`UEF_PTR_W-1:0]           fwPtrSel;
  wire [`UEF_PTR_W-1:0]           rxPtrDrain;
  wire [`UEF_PTR_W-1:0]           txPtrSel;
  wire                            selWr;
  wire                            epSelOk;
  wire                            txEpOk;

  assign stWr  = sfrWr & (sfrAddr == `UEF_ADDR_STATUS);
  assign datWr = sfrWr & (sfrAddr == `UEF_ADDR_DATA);
  assign datRd = sfrRd & (sfrAddr == `UEF_ADDR_DATA);
  assign selWr = sfrWr & (sfrAddr == `UEF_ADDR_EPSEL);

  // selector 7 has no endpoint behind it; its status and count read as zero
  assign epSelOk = (epSel_q < `UEF_NUM_EP);
  assign txEpOk  = (txEp < `UEF_NUM_EP);

  // the buffer has one write port; a firmware write holds the drain for a cycle
  assign drainReady = ~datWr;
  assign drain      = drainValid & drainReady;
  assign drainEp    = drainWord[`UEF_FIFO_W-1:8];

  uef_fifo #(
    .W     (`UEF_FIFO_W),
    .DEPTH (`UEF_FIFO_DEPTH),
    .AW    (`UEF_FIFO_AW)
  ) u_rxFifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .inData   ({rxEp, rxData}),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (drainWord)
  );

  assign fwPtrSel   = fwPtrFlat[epSel_q*`UEF_PTR_W +: `UEF_PTR_W];
  assign rxPtrDrain = rxPtrFlat[drainEp*`UEF_PTR_W +: `UEF_PTR_W];
  assign txPtrSel   = txPtrFlat[txEp*`UEF_PTR_W +: `UEF_PTR_W];

  genvar i;
  generate
    for (i = 0; i < `UEF_NUM_EP; i = i + 1) begin : g_ep
      reg  [`UEF_PTR_W-1:0] fwPtr_q;
      reg  [`UEF_PTR_W-1:0] rxPtr_q;
      reg  [`UEF_PTR_W-1:0] txPtr_q;
      reg  [`UEF_PTR_W-1:0] txCnt_q;
      reg  [`UEF_PTR_W-1:0] byteCnt_q;
      reg                   stall_request_q;
      reg                   tx_packet_ready_q;
      reg                   stall_sent_or_crc_error_q;
      reg                   setup_q;
      reg                   outB0_q;
      reg                   outB1_q;
      reg                   tx_complete_q;
      wire                  hit;
      wire                  sel;
      wire                  wr;
      wire                  iso;
      wire                  bank1;

      assign hit   = (evEp == i);
      assign sel   = (epSel_q == i);
      assign wr    = stWr & sel;
      assign iso   = epIso[i];
      assign bank1 = epPingPong[i] & evOutBank;

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stall_request_q <= 1'b0;
          tx_packet_ready_q   <= 1'b0;
          stall_sent_or_crc_error_q  <= 1'b0;
          setup_q   <= 1'b0;
          outB0_q   <= 1'b0;
          outB1_q   <= 1'b0;
          tx_complete_q  <= 1'b0;
        end else if (hit && evSetup) begin
          setup_q   <= 1'b1;
          stall_request_q <= 1'b0;
          tx_packet_ready_q   <= 1'b0;
          stall_sent_or_crc_error_q  <= 1'b0;
          outB0_q   <= 1'b0;
          outB1_q   <= 1'b0;
          tx_complete_q  <= 1'b0;
        end else begin
          if (wr) begin
            stall_request_q <= sfrWdata[`UEF_B_STALLREQ];
          end
          if (hit && ((evInAck && !iso) || (evInSent && iso))) begin
            tx_packet_ready_q <= 1'b0;
          end else if (wr) begin
            tx_packet_ready_q <= sfrWdata[`UEF_B_TXREADY];
          end
          if (iso) begin
            if (hit && evOut) begin
              stall_sent_or_crc_error_q <= evOutCrcErr;
            end
          end else if (hit && evStallSent && stall_request_q) begin
            // only a STALL that firmware asked for counts as sent
            stall_sent_or_crc_error_q <= 1'b1;
          end else if (wr && !sfrWdata[`UEF_B_STLERR]) begin
            stall_sent_or_crc_error_q <= 1'b0;
          end
          // flags clear on a written zero; a written one leaves them alone
          if (wr && !sfrWdata[`UEF_B_SETUP]) begin
            setup_q <= 1'b0;
          end
          if (hit && evOut && !bank1) begin
            outB0_q <= 1'b1;
          end else if (wr && !sfrWdata[`UEF_B_OUTB0]) begin
            outB0_q <= 1'b0;
          end
          if (hit && evOut && bank1) begin
            outB1_q <= 1'b1;
          end else if (wr && !sfrWdata[`UEF_B_OUTB1]) begin
            outB1_q <= 1'b0;
          end
          if (hit && evInAck && !iso) begin
            tx_complete_q <= 1'b1;
          end else if (wr && !sfrWdata[`UEF_B_TXDONE]) begin
            tx_complete_q <= 1'b0;
          end
        end
      end

      // a status write rewinds the firmware pointer for the next packet
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          fwPtr_q <= `UEF_PTR_ZERO;
          txCnt_q <= `UEF_PTR_ZERO;
        end else begin
          if (wr) begin
            fwPtr_q <= `UEF_PTR_ZERO;
          end else if (sel && (datWr || datRd)) begin
            fwPtr_q <= fwPtr_q + `UEF_PTR_ONE;
          end
          if (wr && sfrWdata[`UEF_B_TXREADY]) begin
            txCnt_q <= fwPtr_q;
          end
        end
      end

      // iso packets land at the start of the buffer whatever the flags
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          rxPtr_q   <= `UEF_PTR_ZERO;
          byteCnt_q <= `UEF_PTR_ZERO;
        end else if (hit && (evOut || evSetup)) begin
          rxPtr_q   <= `UEF_PTR_ZERO;
          byteCnt_q <= rxPtr_q;
        end else if (drain && (drainEp == i)) begin
          rxPtr_q <= rxPtr_q + `UEF_PTR_ONE;
        end
      end

      // an acknowledged or sent packet rewinds the fetch pointer for the next one
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          txPtr_q <= `UEF_PTR_ZERO;
        end else if (hit && (evInAck || evInSent)) begin
          txPtr_q <= `UEF_PTR_ZERO;
        end else if (txRdStb && (txEp == i)) begin
          txPtr_q <= txPtr_q + `UEF_PTR_ONE;
        end
      end

      // firmware's view of the status byte, one bit per flag
      assign statusFlat[8*i + `UEF_B_TXDONE]   = tx_complete_q;
      assign statusFlat[8*i + `UEF_B_OUTB0]    = outB0_q;
      assign statusFlat[8*i + `UEF_B_SETUP]    = setup_q;
      assign statusFlat[8*i + `UEF_B_STLERR]   = stall_sent_or_crc_error_q;
      assign statusFlat[8*i + `UEF_B_TXREADY]  = tx_packet_ready_q;
      assign statusFlat[8*i + `UEF_B_STALLREQ] = stall_request_q;
      assign statusFlat[8*i + `UEF_B_OUTB1]    = outB1_q;
      assign statusFlat[8*i + `UEF_B_RSVD]     = 1'b0;
      assign fwPtrFlat[`UEF_PTR_W*i +: `UEF_PTR_W]   = fwPtr_q;
      assign rxPtrFlat[`UEF_PTR_W*i +: `UEF_PTR_W]   = rxPtr_q;
      assign txPtrFlat[`UEF_PTR_W*i +: `UEF_PTR_W]   = txPtr_q;
      assign txCntFlat[`UEF_PTR_W*i +: `UEF_PTR_W]   = txCnt_q;
      assign byteCntFlat[`UEF_PTR_W*i +: `UEF_PTR_W] = byteCnt_q;
      assign stall_request[i] = stall_request_q;
      assign tx_packet_ready[i]   = tx_packet_ready_q;
      // ping-pong endpoints only refuse once both banks are full
      assign nakNext[i] = ~iso & outB0_q & (~epPingPong[i] | outB1_q);
      assign irqNext[i] = setup_q | outB0_q | outB1_q | tx_complete_q | (stall_sent_or_crc_error_q & ~iso);
    end
  endgenerate

  // buffer memory: firmware write has the port, otherwise the fifo drains
  always @(posedge clk) begin
    if (datWr) begin
      mem[{epSel_q, fwPtrSel}] <= sfrWdata;
    end else if (drain) begin
      mem[{drainEp, rxPtrDrain}] <= drainWord[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      epSel_q <= `UEF_EPSEL_RST;
    end else if (selWr) begin
      epSel_q <= sfrWdata[`UEF_EP_W-1:0];
    end
  end

  // register read data appears on the edge after the read strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdata_q <= `UEF_BYTE_ZERO;
    end else if (sfrRd) begin
      case (sfrAddr)
        `UEF_ADDR_EPSEL: begin
          sfrRdata_q <= {{(8-`UEF_EP_W){1'b0}}, epSel_q};
        end
        `UEF_ADDR_STATUS: begin
          sfrRdata_q <= epSelOk ? statusFlat[epSel_q*8 +: 8] : `UEF_BYTE_ZERO;
        end
        `UEF_ADDR_DATA: begin
          sfrRdata_q <= mem[{epSel_q, fwPtrSel}];
        end
        `UEF_ADDR_COUNT: begin
          sfrRdata_q <= epSelOk ?
                        {1'b0, byteCntFlat[epSel_q*`UEF_PTR_W +: `UEF_PTR_W]} : `UEF_BYTE_ZERO;
        end
        default: begin
          sfrRdata_q <= `UEF_BYTE_ZERO;
        end
      endcase
    end
  end

  // serial engine side; txLen of zero with packet ready means a zero length packet
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txData_q <= `UEF_BYTE_ZERO;
      txLen_q  <= `UEF_PTR_ZERO;
      rxIdle_q <= 1'b1;
    end else begin
      txData_q <= txEpOk ? mem[{txEp, txPtrSel}] : `UEF_BYTE_ZERO;
      txLen_q  <= txEpOk ? txCntFlat[txEp*`UEF_PTR_W +: `UEF_PTR_W] : `UEF_PTR_ZERO;
      // idle only once nothing waits in the fifo, so an event never beats its own bytes
      rxIdle_q <= ~drainValid & ~rxValid;
    end
  end

  // per-endpoint levels for the serial engine, one flop behind the flags
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      epStallReq_q <= {`UEF_NUM_EP{1'b0}};
      epTxReady_q  <= {`UEF_NUM_EP{1'b0}};
      epNakOut_q   <= {`UEF_NUM_EP{1'b0}};
      epIrq_q      <= {`UEF_NUM_EP{1'b0}};
    end else begin
      epStallReq_q <= stall_request;
      epTxReady_q  <= tx_packet_ready;
      epNakOut_q   <= nakNext;
      epIrq_q      <= irqNext;
    end
  end
endmodule // uef_endpoint_access

// *** verification/uef_monitor.sv ***
// port-level assertions for the endpoint status and fifo access block
`timescale 1ns/1ps
module uef_monitor (
  // clock and reset
  input wire       clk,
  input wire       rst_b,
  // register port
  input wire [7:0] sfrAddr,
  input wire       sfrWr,
  input wire       sfrRd,
  input wire [7:0] sfrRdata_q,
  // configuration and events
  input wire [6:0] epIso,
  input wire [6:0] epPingPong,
  input wire [2:0] evEp,
  input wire       evSetup,
  input wire       evOut,
  input wire       evOutBank,
  input wire       evInAck,
  input wire       evStallSent,
  // handshake steering
  input wire [6:0] epStallReq_q,
  input wire [6:0] epTxReady_q,
  input wire [6:0] epNakOut_q,
  input wire [6:0] epIrq_q
);
  reg [2:0] lastEp_q;
  // events are spaced, so the last event endpoint stays put while its effect lands
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) lastEp_q <= 3'h0;
    else if (evSetup | evOut | evInAck | evStallSent) lastEp_q <= evEp;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_bycTop; sfrRd && sfrAddr == 8'he2 |=> !sfrRdata_q[7]; endproperty
  a_bycTop: assert property (p_bycTop) else $error("count top bit set");
  property p_rdHold; !sfrRd |=> $stable(sfrRdata_q); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  property p_setupClr; evSetup |-> ##3 !epTxReady_q[lastEp_q] && !epStallReq_q[lastEp_q]; endproperty
  a_setupClr: assert property (p_setupClr) else $error("setup left bits set");
  property p_setupIrq; evSetup |-> ##[1:4] epIrq_q[lastEp_q]; endproperty
  a_setupIrq: assert property (p_setupIrq) else $error("no setup interrupt");
  property p_outIrq; evOut |-> ##[1:4] epIrq_q[lastEp_q]; endproperty
  a_outIrq: assert property (p_outIrq) else $error("no out interrupt");
  property p_outNak; evOut && !evOutBank && !epIso[evEp] && !epPingPong[evEp] |-> ##[1:4] epNakOut_q[lastEp_q];
  endproperty
  a_outNak: assert property (p_outNak) else $error("no nak after out");
  property p_isoNak; (epNakOut_q & epIso) == 7'h00; endproperty
  a_isoNak: assert property (p_isoNak) else $error("iso endpoint naks");
  property p_ackClr; evInAck && !epIso[evEp] |-> ##3 !epTxReady_q[lastEp_q]; endproperty
  a_ackClr: assert property (p_ackClr) else $error("ready kept after ack");
  property p_ackIrq; evInAck && !epIso[evEp] |-> ##[1:4] epIrq_q[lastEp_q]; endproperty
  a_ackIrq: assert property (p_ackIrq) else $error("no complete interrupt");
  property p_stallIrq; evStallSent && epStallReq_q[evEp] && !epIso[evEp] |-> ##[1:4] epIrq_q[lastEp_q];
  endproperty
  a_stallIrq: assert property (p_stallIrq) else $error("no stall interrupt");
  property p_irqHold; |($past(epIrq_q) & ~epIrq_q) |-> $past(sfrWr) || $past(sfrWr, 2) || $past(sfrWr, 3);
  endproperty
  a_irqHold: assert property (p_irqHold) else $error("flag dropped alone");
endmodule // uef_monitor

bind uef_endpoint_access uef_monitor u_uef_monitor (
  .clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdata_q(sfrRdata_q),
  .epIso(epIso), .epPingPong(epPingPong), .evEp(evEp), .evSetup(evSetup), .evOut(evOut),
  .evOutBank(evOutBank), .evInAck(evInAck), .evStallSent(evStallSent), .epStallReq_q(epStallReq_q),
  .epTxReady_q(epTxReady_q), .epNakOut_q(epNakOut_q), .epIrq_q(epIrq_q));

// *** verification/uef_host_model.sv ***
// serial engine stand-in: received bytes, packet events and transmit fetches
`timescale 1ns/1ps
module uef_host_model (
  // clock
  input  wire       clk,
  // receive path
  output reg        rxValid,
  output reg  [2:0] rxEp,
  output reg  [7:0] rxData,
  input  wire       rxReady,
  input  wire       rxIdle_q,
  // packet events, one at a time
  output reg  [2:0] evEp,
  output reg        evSetup, evOut, evOutBank, evOutCrcErr, evInAck, evInSent, evStallSent,
  // transmit fetch
  output reg        txRdStb,
  output reg  [2:0] txEp
);
  integer i;
  initial begin
    {rxValid, rxEp, rxData, evEp, txRdStb, txEp} = 19'h00000;
    {evSetup, evOut, evOutBank, evOutCrcErr, evInAck, evInSent, evStallSent} = 7'h00;
  end
  // idle data is inverted so a stale byte can never be taken for a fresh one
  task send(input [2:0] ep, input [7:0] n, input [7:0] base);
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(negedge clk);
        rxValid = 1'b1;
        rxEp = ep;
        rxData = base + i[7:0];
        while (!rxReady) @(negedge clk);
      end
      @(negedge clk);
      rxValid = 1'b0;
      rxData = ~rxData;
    end
  endtask
  // kind: 0 setup, 1 out, 2 in ack, 3 iso in sent, 4 stall sent
  task pulse(input [2:0] kind, input [2:0] ep, input bank, input crc);
    integer w;
    begin
      w = 0;
      @(negedge clk);
      while (!rxIdle_q && w < 50) begin
        @(negedge clk);
        w = w + 1;
      end
      evEp = ep;
      evOutBank = bank;
      evOutCrcErr = crc;
      case (kind)
        3'h0: evSetup = 1'b1;
        3'h1: evOut = 1'b1;
        3'h2: evInAck = 1'b1;
        3'h3: evInSent = 1'b1;
        default: evStallSent = 1'b1;
      endcase
      @(negedge clk);
      {evSetup, evOut, evInAck, evInSent, evStallSent} = 5'h00;
      repeat (4) @(negedge clk);
    end
  endtask
  task fetch;
    begin
      txRdStb = 1'b1;
      @(negedge clk);
      txRdStb = 1'b0;
      @(negedge clk);
    end
  endtask
endmodule // uef_host_model

// *** verification/uef_endpoint_access_tb.sv ***
// self-checking bench for the endpoint status and fifo access block
`timescale 1ns/1ps
module uef_endpoint_access_tb;
  reg        clk, rst_b, sfrWr, sfrRd;
  reg  [7:0] sfrAddr, sfrWdata;
  reg  [6:0] epIso, epPingPong;
  wire [7:0] sfrRdata_q, txData_q, rxData;
  wire [6:0] txLen_q, epStallReq_q, epTxReady_q, epNakOut_q, epIrq_q;
  wire [2:0] rxEp, evEp, txEp;
  wire       rxValid, rxReady, rxIdle_q, evSetup, evOut, evOutBank, evOutCrcErr, evInAck, evInSent;
  wire       evStallSent, txRdStb;
  integer    err_total, cmp_count, i;
  uef_endpoint_access u_uef_endpoint_access (.clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata_q(sfrRdata_q), .epIso(epIso), .epPingPong(epPingPong),
    .rxValid(rxValid), .rxEp(rxEp), .rxData(rxData), .rxReady(rxReady), .rxIdle_q(rxIdle_q), .evEp(evEp),
    .evSetup(evSetup), .evOut(evOut), .evOutBank(evOutBank), .evOutCrcErr(evOutCrcErr), .evInAck(evInAck),
    .evInSent(evInSent), .evStallSent(evStallSent), .txRdStb(txRdStb), .txEp(txEp), .txData_q(txData_q),
    .txLen_q(txLen_q), .epStallReq_q(epStallReq_q), .epTxReady_q(epTxReady_q), .epNakOut_q(epNakOut_q),
    .epIrq_q(epIrq_q));
  uef_host_model u_uef_host_model (.clk(clk), .rxValid(rxValid), .rxEp(rxEp), .rxData(rxData),
    .rxReady(rxReady), .rxIdle_q(rxIdle_q), .evEp(evEp), .evSetup(evSetup), .evOut(evOut),
    .evOutBank(evOutBank), .evOutCrcErr(evOutCrcErr), .evInAck(evInAck), .evInSent(evInSent),
    .evStallSent(evStallSent), .txRdStb(txRdStb), .txEp(txEp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      sfrWr = 1'b1;
      sfrAddr = a;
      sfrWdata = d;
      @(negedge clk);
      sfrWr = 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk);
      sfrRd = 1'b1;
      sfrAddr = a;
      @(negedge clk);
      sfrRd = 1'b0;
      chk(sfrRdata_q, e);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // a few hundred cycles are expected; far more means a hang
  initial begin
    #2000000;
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    {err_total, cmp_count} = 0;
    {rst_b, sfrWr, sfrRd, sfrAddr, sfrWdata} = 19'h00000;
    epIso = 7'h08;
    epPingPong = 7'h40;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    rdc(8'hce, 8'h00);
    wr(8'h00, 8'hff);
    rdc(8'h00, 8'h00);
    $display("test reset done");
    wr(8'hc7, 8'h01);
    u_uef_host_model.send(3'h1, 8'h05, 8'h30);
    u_uef_host_model.pulse(3'h1, 3'h1, 1'b0, 1'b0);
    rdc(8'he2, 8'h05);
    rdc(8'hce, 8'h02);
    chk({7'h00, epNakOut_q[1]}, 8'h01);
    chk({7'h00, epIrq_q[1]}, 8'h01);
    for (i = 0; i < 5; i = i + 1) rdc(8'hcf, 8'h30 + i[7:0]);
    rdc(8'hce, 8'h02);
    wr(8'hce, 8'h00);
    rdc(8'hce, 8'h00);
    chk({7'h00, epIrq_q[1]}, 8'h00);
    $display("test bulk out done");
    wr(8'hc7, 8'h00);
    wr(8'hce, 8'h20);
    u_uef_host_model.pulse(3'h4, 3'h0, 1'b0, 1'b0);
    rdc(8'hce, 8'h28);
    chk({7'h00, epStallReq_q[0]}, 8'h01);
    u_uef_host_model.send(3'h0, 8'h08, 8'h50);
    u_uef_host_model.pulse(3'h0, 3'h0, 1'b0, 1'b0);
    rdc(8'hce, 8'h04);
    chk({7'h00, epStallReq_q[0]}, 8'h00);
    rdc(8'he2, 8'h08);
    for (i = 0; i < 8; i = i + 1) rdc(8'hcf, 8'h50 + i[7:0]);
    wr(8'hce, 8'h00);
    rdc(8'hce, 8'h00);
    $display("test setup done");
    wr(8'hc7, 8'h02);
    for (i = 0; i < 3; i = i + 1) wr(8'hcf, 8'h70 + i[7:0]);
    wr(8'hce, 8'h10);
    u_uef_host_model.txEp = 3'h2;
    rdc(8'hce, 8'h10);
    chk({1'b0, txLen_q}, 8'h03);
    chk({7'h00, epTxReady_q[2]}, 8'h01);
    for (i = 0; i < 3; i = i + 1) begin
      chk(txData_q, 8'h70 + i[7:0]);
      u_uef_host_model.fetch;
    end
    u_uef_host_model.pulse(3'h2, 3'h2, 1'b0, 1'b0);
    rdc(8'hce, 8'h01);
    chk({7'h00, epTxReady_q[2]}, 8'h00);
    wr(8'hce, 8'h00);
    wr(8'hce, 8'h10);
    rdc(8'hce, 8'h10);
    chk({1'b0, txLen_q}, 8'h00);
    $display("test bulk in done");
    wr(8'hc7, 8'h03);
    u_uef_host_model.send(3'h3, 8'h02, 8'h90);
    u_uef_host_model.pulse(3'h1, 3'h3, 1'b0, 1'b1);
    rdc(8'hce, 8'h0a);
    chk({7'h00, epNakOut_q[3]}, 8'h00);
    u_uef_host_model.send(3'h3, 8'h04, 8'ha0);
    u_uef_host_model.pulse(3'h1, 3'h3, 1'b0, 1'b0);
    rdc(8'he2, 8'h04);
    rdc(8'hce, 8'h02);
    rdc(8'hcf, 8'ha0);
    wr(8'hce, 8'h1a);
    rdc(8'hce, 8'h12);
    u_uef_host_model.pulse(3'h3, 3'h3, 1'b0, 1'b0);
    rdc(8'hce, 8'h02);
    $display("test iso done");
    wr(8'hc7, 8'h06);
    u_uef_host_model.send(3'h6, 8'h01, 8'hc0);
    u_uef_host_model.pulse(3'h1, 3'h6, 1'b1, 1'b0);
    rdc(8'hce, 8'h40);
    chk({7'h00, epNakOut_q[6]}, 8'h00);
    u_uef_host_model.send(3'h6, 8'h01, 8'hc1);
    u_uef_host_model.pulse(3'h1, 3'h6, 1'b0, 1'b0);
    rdc(8'hce, 8'h42);
    chk({7'h00, epNakOut_q[6]}, 8'h01);
    $display("test ping-pong done");
    tally_and_finish;
  end
endmodule // uef_endpoint_access_tb
